// [dv/dosc_line_src.sv]
// host side model: line triggers and the sensor pixel stream
`timescale 1ns/10ps
module dosc_line_src import dosc_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // control from the bench
  input wire logic start,
  input wire logic [7:0] pairs,
  input wire logic slow,
  output logic busy,
  // pixel stream
  output dosc_pix_in_t pix_in,
  input wire logic pix_in_ready
);
  initial begin
    pix_in = '0;
    busy = 1'h0;
    forever begin
      @(posedge ref_clk);
      if (start && resetn) begin
        busy <= 1'h1;
        // one trigger per line pair, as many as the bench asks for
        for (int p = 0; p < pairs; p++) begin
          for (int n = 0; n < 2 * NPIX; n++) begin
            pix_in <= {1'h1, n[4], n[3:0] == 4'hf, n[3:0], n[4] ? 12'h020 - {n[3:0], 1'h0} : {8'h00, n[3:0]}};
            do @(posedge ref_clk); while (pix_in_ready !== 1'h1);
            if (slow) begin
              // idle word carries inverted data so a stale value never looks live
              pix_in <= {1'h0, ~pix_in[17:0]};
              @(posedge ref_clk);
            end
          end
        end
        pix_in <= {1'h0, ~pix_in[17:0]};
        busy <= 1'h0;
      end
    end
  end
endmodule

// [dv/dosc_properties.sv]
// port checker for the shading block
`timescale 1ns/10ps
module dosc_checker import dosc_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  // pixel streams
  input wire dosc_pix_in_t pix_in,
  input wire logic pix_in_ready,
  input wire dosc_pix_out_t pix_out,
  input wire logic pix_out_ready,
  // state
  input wire logic cal_busy
);
  logic [6:0] pairs_reg;
  logic gen_wr;
  assign gen_wr = reg_wr && !cal_busy && reg_addr == ADDR_GENERATE;
  // --------------------------------
  // line pairs taken during a run
  // --------------------------------
  // saturates so a stuck run never wraps back under the minimum
  always_ff @(posedge ref_clk) begin
    if (!resetn || !cal_busy) begin
      pairs_reg <= 7'h00;
    end else if (pix_in.valid && pix_in_ready && pix_in.last && pix_in.line_sel && pairs_reg != 7'h7f) begin
      pairs_reg <= pairs_reg + 7'h01;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // --------------------------------
  // properties
  // --------------------------------
  property p_ack_cause;
    reg_ack |-> $past(reg_wr || reg_rd) && !$past(cal_busy);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without an accepted strobe");
  property p_ack_next;
    (reg_wr || reg_rd) && !cal_busy |=> reg_ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("accepted strobe not acknowledged");
  property p_rdata_idle;
    !$past(reg_rd && !cal_busy) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
  property p_gen_start;
    gen_wr && reg_wdata[1:0] == GEN_DARK |=> cal_busy;
  endproperty
  a_gen_start: assert property (p_gen_start) else $error("dark generate code did not start a run");
  property p_gen_other;
    gen_wr && reg_wdata[1:0] != GEN_DARK |=> !cal_busy;
  endproperty
  a_gen_other: assert property (p_gen_other) else $error("other generate code started a run");
  property p_busy_cause;
    $rose(cal_busy) |-> $past(gen_wr && reg_wdata[1:0] == GEN_DARK);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy rose without a generate write");
  property p_min_lines;
    $fell(cal_busy) |-> pairs_reg >= 7'h40;
  endproperty
  a_min_lines: assert property (p_min_lines) else $error("run ended before 64 line pairs");
  property p_finish;
    $rose(pairs_reg == 7'h40) |-> ##[1:48] !cal_busy;
  endproperty
  a_finish: assert property (p_finish) else $error("run did not finish after 64 line pairs");
  property p_hold;
    pix_out.data_valid && !pix_out_ready |=> $stable(pix_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output word changed while stalled");
  property p_valid_pair;
    pix_out.data_valid |-> pix_out.line_valid;
  endproperty
  a_valid_pair: assert property (p_valid_pair) else $error("data valid without line valid");
endmodule

// [dv/tb.sv]
// self-checking bench for the shading block
`timescale 1ns/10ps
module tb import dosc_pkg::*; ();
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic reg_ack;
  dosc_pix_in_t pix_in;
  logic pix_in_ready;
  dosc_pix_out_t pix_out;
  logic pix_out_ready = 1'h1;
  logic cal_busy;
  logic start = 1'h0;
  logic [7:0] pairs = 8'h01;
  logic slow = 1'h0;
  logic src_busy;
  logic [1:0] rmode = 2'h0;
  logic [14:0] exp_q[$];
  logic [14:0] e;
  int n_mismatch = 0;
  int total_checks = 0;
  int k;
  // mode, table select, single line, offsets expected
  logic [4:0] rows [7] = '{5'h04, 5'h0d, 5'h14, 5'h1d, 5'h08, 5'h0e, 5'h0d};
  dosc_top #(.DEPTH(16)) u_dosc_top (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_ack, .pix_in, .pix_in_ready, .pix_out, .pix_out_ready, .cal_busy);
  dosc_line_src u_dosc_line_src (.ref_clk, .resetn, .start, .pairs, .slow, .busy(src_busy), .pix_in,
    .pix_in_ready);
  always #10 ref_clk = ~ref_clk;
  // --------------------------------
  // helpers
  // --------------------------------
  task automatic close_out();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] x, input logic [31:0] got);
    total_checks++;
    if (got !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, x, got);
    end
  endtask
  // status holds a live line count, so only its two flags are compared
  task automatic acc(input logic rd, input logic [7:0] a, input logic [31:0] d, input logic ack);
    @(posedge ref_clk);
    reg_rd <= rd;
    reg_wr <= !rd;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    reg_wr <= 1'h0;
    #1;
    chk("reg_ack", 32'(ack), 32'(reg_ack));
    chk("reg_rdata", rd && ack ? d : 32'h0, reg_rdata & (a == ADDR_STATUS ? 32'h3 : 32'hffffffff));
  endtask
  function automatic logic cond(input int sel);
    case (sel)
      0: return src_busy;
      1: return cal_busy;
      2: return exp_q.size() != 0;
      default: return pix_in_ready;
    endcase
  endfunction
  task automatic wait_clear(input int sel, input int lim);
    k = 0;
    while (cond(sel) !== 1'h0 && k < lim) begin
      @(posedge ref_clk);
      k++;
    end
    chk("wait", 32'h0, 32'(cond(sel)));
  endtask
  function automatic logic [11:0] expv(input logic ls, input logic [3:0] i, input int rs, input int rl);
    if (i >= rs && i < rs + rl) begin
      return ls ? 12'h020 - 12'(2 * rs) : 12'(rs + rl - 1);
    end
    return ls ? 12'h020 - {i, 1'h0} : {8'h00, i};
  endfunction
  task automatic launch(input logic [7:0] n, input logic s, input logic ck, input int rs, input int rl, input bit w);
    for (int p = 0; p < n; p++) begin
      for (int i = 0; i < 2 * NPIX; i++) begin
        exp_q.push_back({ck, i[4], i[3:0] == 4'hf, expv(i[4], i[3:0], rs, rl)});
      end
    end
    @(posedge ref_clk);
    pairs <= n;
    slow <= s;
    start <= 1'h1;
    @(posedge ref_clk);
    start <= 1'h0;
    @(posedge ref_clk);
    if (w) begin
      wait_clear(0, 9000);
      wait_clear(2, 200);
    end
  endtask
  // --------------------------------
  // grabber side
  // --------------------------------
  always @(posedge ref_clk) begin
    pix_out_ready <= rmode == 2'h0 || (rmode == 2'h2 && !pix_out_ready);
    if (resetn && pix_out.data_valid === 1'h1 && pix_out_ready) begin
      e = exp_q.size() != 0 ? exp_q.pop_front() : 15'h7fff;
      if (e[14]) begin
        chk("pix_out", {18'h0, e[13:0]}, {18'h0, pix_out.line_sel, pix_out.last, pix_out.data});
      end
    end
  end
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_mismatch++;
    close_out();
  end
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'h1;
    acc(1, ADDR_MODE, 32'h0, 1);
    acc(1, ADDR_STATUS, 32'h0, 1);
    for (int c = 0; c < 4; c++) begin
      if (c != 1) begin
        acc(0, ADDR_GENERATE, 32'(c), 1);
      end
    end
    chk("cal_busy", 32'h0, 32'(cal_busy));
    acc(0, ADDR_MODE, 32'(MODE_DARK), 1);
    acc(0, ADDR_GENERATE, 32'(GEN_DARK), 1);
    chk("cal_busy", 32'h1, 32'(cal_busy));
    acc(0, ADDR_MODE, 32'(MODE_OFF), 0);
    acc(1, ADDR_MODE, 32'h0, 0);
    acc(0, ADDR_TABLE_SEL, 32'h0, 0);
    launch(64, 0, 0, 0, 0, 1);
    wait_clear(1, 100);
    acc(1, ADDR_STATUS, 32'h2, 1);
    for (int r = 0; r < 7; r++) begin
      acc(0, ADDR_MODE, 32'(rows[r][4:3]), 1);
      acc(0, ADDR_TABLE_SEL, 32'(rows[r][2]), 1);
      acc(0, ADDR_ACQ_MODE, 32'(rows[r][1]), 1);
      acc(1, ADDR_MODE, 32'(rows[r][4:3]), 1);
      launch(1, 0, 1, 0, rows[r][0] ? 16 : 0, 1);
    end
    // narrow region, single line set, slow source and a stalling grabber
    acc(0, ADDR_ACQ_MODE, 32'h1, 1);
    acc(0, ADDR_ROI_START, 32'h4, 1);
    acc(0, ADDR_ROI_LEN, 32'h8, 1);
    acc(1, ADDR_ROI_START, 32'h4, 1);
    acc(0, ADDR_GENERATE, 32'(GEN_DARK), 1);
    rmode <= 2'h2;
    launch(64, 1, 0, 0, 0, 1);
    wait_clear(1, 100);
    rmode <= 2'h0;
    launch(1, 0, 1, 4, 8, 1);
    // fill the buffer until it refuses, then drain it
    rmode <= 2'h1;
    launch(1, 0, 1, 4, 8, 0);
    wait_clear(3, 100);
    rmode <= 2'h0;
    wait_clear(0, 500);
    wait_clear(2, 200);
    // reset in the middle of a run
    acc(0, ADDR_GENERATE, 32'(GEN_DARK), 1);
    launch(2, 0, 0, 0, 0, 1);
    resetn <= 1'h0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'h1;
    #1;
    chk("cal_busy", 32'h0, 32'(cal_busy));
    acc(1, ADDR_MODE, 32'h0, 1);
    acc(1, ADDR_STATUS, 32'h0, 1);
    acc(1, ADDR_ROI_LEN, 32'h10, 1);
    acc(1, ADDR_TABLE_SEL, 32'h0, 1);
    acc(1, ADDR_ACQ_MODE, 32'h0, 1);
    acc(1, 8'h1c, 32'h0, 1);
    close_out();
  end
endmodule
bind dosc_top dosc_checker #(.DEPTH(DEPTH)) u_dosc_checker (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .reg_ack, .pix_in, .pix_in_ready, .pix_out, .pix_out_ready, .cal_busy);

// [hdl/dosc_pkg.sv]
// constants and types of the dark offset shading calibration block
package dosc_pkg;
  // ----------------------------------------------------------------
  // stream geometry
  // ----------------------------------------------------------------
  localparam int PIX_W = 12;
  localparam int NPIX = 16;
  localparam int IDX_W = $clog2(NPIX);
  localparam int NLINES = 2;
  localparam int NSETS = 2;
  localparam int CAL_LINES = 64;
  localparam int CAL_SHIFT = 6;
  localparam int ACC_W = PIX_W + CAL_SHIFT;
  localparam int GAIN_W = 12;
  localparam int GAIN_FRAC = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_SLACK = 3;
  // ----------------------------------------------------------------
  // table contents
  // ----------------------------------------------------------------
  localparam logic [PIX_W-1:0] FACT_OFFSET = 12'h000;
  localparam logic [GAIN_W-1:0] GAIN_UNITY = 12'h400;
  localparam logic SET_SINGLE = 1'h0;
  localparam logic SET_OTHER = 1'h1;
  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_GENERATE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_ACQ_MODE = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_ROI_START = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_ROI_LEN = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_TABLE_SEL = 8'h18;
  localparam int MODE_LSB = 0;
  localparam int GEN_LSB = 0;
  localparam int GEN_W = 2;
  localparam logic [GEN_W-1:0] GEN_DARK = 2'h1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_USER = 1;
  localparam int STAT_CNT_LSB = 8;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_DARK = 2'b01,
    MODE_GAIN = 2'b10,
    MODE_BOTH = 2'b11
  } dosc_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACC = 2'b01,
    ST_SCAN = 2'b10,
    ST_WRITE = 2'b11
  } dosc_state_t;
  typedef struct packed {
    logic valid;
    logic line_sel;
    logic last;
    logic [IDX_W-1:0] idx;
    logic [PIX_W-1:0] data;
  } dosc_pix_in_t;
  typedef struct packed {
    logic line_valid;
    logic data_valid;
    logic line_sel;
    logic last;
    logic [PIX_W-1:0] data;
  } dosc_pix_out_t;
endpackage

// [hdl/dosc_top.sv]
// shading correction datapath, dark offset calibration and output fifo
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Functional notes
// - offset only, gain only, or both
// - factory and user tables, offset and gain
// - factory table has no write path
// - single line mode set, other modes set
// - outside roi copy previous active table
// - mode register selects correction
// - generate code starts dark calibration
// - collect 64 lines before computing
// - stream keeps flowing during calibration
// - commands ignored, unacknowledged while calibrating
// - average per pixel per sensor line
// - brightest average is the reference
// - offset lifts each pixel inside the roi to reference
// - offsets overwrite the user table
// - user table activated at completion
// ----------------------------------------------------------------

// ----------------------------------------------------------------
// synchronous fifo, flop storage
// ----------------------------------------------------------------
module dosc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // fill level
  output logic [$clog2(DEPTH):0] count
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;
  assign in_ready = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign count = count_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------------------------------
// top of the shading block
// ----------------------------------------------------------------
module dosc_top import dosc_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  // sensor pixel stream in
  input wire dosc_pix_in_t pix_in,
  output logic pix_in_ready,
  // corrected stream to the grabber
  output dosc_pix_out_t pix_out,
  input wire logic pix_out_ready,
  // state
  output logic cal_busy
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic in_roi(input logic [IDX_W-1:0] idx, input logic [IDX_W:0] start,
                                  input logic [IDX_W:0] len);
    logic [IDX_W+1:0] stop;
    stop = {1'b0, start} + {1'b0, len};
    in_roi = ({1'b0, idx} >= start) && ({2'b00, idx} < stop);
  endfunction
  function automatic logic [PIX_W-1:0] correct(input logic [PIX_W-1:0] d, input logic [PIX_W-1:0] off,
                                               input logic [GAIN_W-1:0] g, input dosc_mode_t mode);
    logic [PIX_W:0] s;
    logic [PIX_W-1:0] x;
    logic [PIX_W+GAIN_W-1:0] p;
    s = {1'b0, d} + {1'b0, off};
    x = d;
    if (mode == MODE_DARK || mode == MODE_BOTH) begin
      x = s[PIX_W] ? '1 : s[PIX_W-1:0];
    end
    p = (PIX_W+GAIN_W)'(x) * (PIX_W+GAIN_W)'(g);
    correct = x;
    if (mode == MODE_GAIN || mode == MODE_BOTH) begin
      correct = (|p[PIX_W+GAIN_W-1:PIX_W+GAIN_FRAC]) ? '1 : p[PIX_W+GAIN_FRAC-1:GAIN_FRAC];
    end
  endfunction

  // ----------------------------------------------------------------
  // registers and storage
  // ----------------------------------------------------------------
  dosc_mode_t mode_reg;
  logic single_line_reg;
  logic [IDX_W:0] roi_start_reg;
  logic [IDX_W:0] roi_len_reg;
  logic active_user_reg;
  logic busy_reg;
  dosc_state_t state_reg;
  logic [6:0] line_cnt_reg;
  logic [IDX_W-1:0] idx_reg;
  logic cal_set_reg;
  logic [PIX_W-1:0] max_reg [0:NLINES-1];
  logic [ACC_W-1:0] acc_reg [0:NLINES-1][0:NPIX-1];
  logic [PIX_W-1:0] user_off_reg [0:NLINES-1][0:NSETS-1][0:NPIX-1];
  logic [GAIN_W-1:0] user_gain_reg [0:NLINES-1][0:NPIX-1];
  logic [31:0] reg_rdata_reg;
  logic reg_ack_reg;
  logic pix_in_ready_reg;
  dosc_pix_out_t stage_reg;
  dosc_pix_out_t pix_out_reg;
  logic wr_ok;
  logic rd_ok;
  logic gen_start;
  logic take;
  logic cur_set;
  logic [PIX_W-1:0] off_sel;
  logic [GAIN_W-1:0] gain_sel;
  logic fifo_out_valid;
  logic fifo_pop;
  dosc_pix_out_t fifo_out;
  logic [$clog2(DEPTH):0] fifo_count;
  // calibration ownership shuts the command port
  assign wr_ok = reg_wr && !busy_reg;
  assign rd_ok = reg_rd && !busy_reg;
  assign gen_start = wr_ok && reg_addr == ADDR_GENERATE
                     && reg_wdata[GEN_LSB +: GEN_W] == GEN_DARK;
  assign take = pix_in.valid && pix_in_ready_reg;
  assign cur_set = single_line_reg ? SET_SINGLE : SET_OTHER;
  // factory values are constants, so nothing can ever rewrite them
  assign off_sel = active_user_reg ? user_off_reg[pix_in.line_sel][cur_set][pix_in.idx] : FACT_OFFSET;
  assign gain_sel = active_user_reg ? user_gain_reg[pix_in.line_sel][pix_in.idx] : GAIN_UNITY;
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode_reg <= MODE_OFF;
      single_line_reg <= 1'b0;
      roi_start_reg <= '0;
      roi_len_reg <= (IDX_W+1)'(NPIX);
    end else if (wr_ok) begin
      case (reg_addr)
        ADDR_MODE: begin
          mode_reg <= dosc_mode_t'(reg_wdata[MODE_LSB +: 2]);
        end
        ADDR_ACQ_MODE: begin
          single_line_reg <= reg_wdata[0];
        end
        ADDR_ROI_START: begin
          roi_start_reg <= reg_wdata[IDX_W:0];
        end
        ADDR_ROI_LEN: begin
          roi_len_reg <= reg_wdata[IDX_W:0];
        end
        default: begin
        end
      endcase
    end
  end
  // read data stand one cycle; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_rdata_reg <= '0;
      reg_ack_reg <= 1'b0;
    end else begin
      reg_ack_reg <= wr_ok || rd_ok;
      reg_rdata_reg <= '0;
      if (rd_ok) begin
        case (reg_addr)
          ADDR_MODE: begin
            reg_rdata_reg <= 32'(mode_reg);
          end
          ADDR_ACQ_MODE: begin
            reg_rdata_reg <= 32'(single_line_reg);
          end
          ADDR_ROI_START: begin
            reg_rdata_reg <= 32'(roi_start_reg);
          end
          ADDR_ROI_LEN: begin
            reg_rdata_reg <= 32'(roi_len_reg);
          end
          ADDR_STATUS: begin
            reg_rdata_reg[STAT_BUSY] <= busy_reg;
            reg_rdata_reg[STAT_USER] <= active_user_reg;
            reg_rdata_reg[STAT_CNT_LSB +: 7] <= line_cnt_reg;
          end
          ADDR_TABLE_SEL: begin
            reg_rdata_reg <= 32'(active_user_reg);
          end
          default: begin
            reg_rdata_reg <= '0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // calibration sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      line_cnt_reg <= '0;
      idx_reg <= '0;
      cal_set_reg <= 1'b0;
      active_user_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (gen_start) begin
            state_reg <= ST_ACC;
            busy_reg <= 1'b1;
            line_cnt_reg <= '0;
            cal_set_reg <= cur_set;
          end else if (wr_ok && reg_addr == ADDR_TABLE_SEL) begin
            active_user_reg <= reg_wdata[0];
          end
        end
        ST_ACC: begin
          // a run begun mid-line counts that partial line too
          if (take && pix_in.last && pix_in.line_sel == 1'(NLINES-1)) begin
            line_cnt_reg <= line_cnt_reg + 1'b1;
            if (line_cnt_reg == 7'(CAL_LINES-1)) begin
              state_reg <= ST_SCAN;
              idx_reg <= '0;
            end
          end
        end
        ST_SCAN: begin
          idx_reg <= idx_reg + 1'b1;
          if (idx_reg == IDX_W'(NPIX-1)) begin
            state_reg <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          idx_reg <= idx_reg + 1'b1;
          if (idx_reg == IDX_W'(NPIX-1)) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
            active_user_reg <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // per pixel sums, reference search and table write
  // ----------------------------------------------------------------
  generate
    for (genvar l = 0; l < NLINES; l++) begin : g_line
      logic [PIX_W-1:0] avg;
      assign avg = acc_reg[l][idx_reg][ACC_W-1:CAL_SHIFT];
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          max_reg[l] <= '0;
        end else if (state_reg == ST_ACC) begin
          max_reg[l] <= '0;
        end else if (state_reg == ST_SCAN && in_roi(idx_reg, roi_start_reg, roi_len_reg)
                     && avg > max_reg[l]) begin
          max_reg[l] <= avg;
        end
      end
      for (genvar p = 0; p < NPIX; p++) begin : g_pix
        always_ff @(posedge ref_clk) begin
          if (!resetn || gen_start) begin
            acc_reg[l][p] <= '0;
          end else if (state_reg == ST_ACC && take && pix_in.line_sel == 1'(l)
                       && pix_in.idx == IDX_W'(p)
                       && in_roi(IDX_W'(p), roi_start_reg, roi_len_reg)) begin
            acc_reg[l][p] <= acc_reg[l][p] + ACC_W'(pix_in.data);
          end
        end
      end
      // line index first, so each line's process owns its own slice of the table
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          for (int s = 0; s < NSETS; s++) begin
            for (int p = 0; p < NPIX; p++) begin
              user_off_reg[l][s][p] <= FACT_OFFSET;
            end
          end
          for (int p = 0; p < NPIX; p++) begin
            user_gain_reg[l][p] <= GAIN_UNITY;
          end
        end else if (state_reg == ST_WRITE) begin
          if (in_roi(idx_reg, roi_start_reg, roi_len_reg)) begin
            user_off_reg[l][cal_set_reg][idx_reg] <= max_reg[l] - avg;
          end else if (!active_user_reg) begin
            user_off_reg[l][cal_set_reg][idx_reg] <= FACT_OFFSET;
          end
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // correction pipeline and output fifo
  // ----------------------------------------------------------------
  // stream is never held for calibration; its content is just not useful
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stage_reg <= '0;
      pix_in_ready_reg <= 1'b0;
    end else begin
      // slack covers the stage register and the ready latency
      pix_in_ready_reg <= fifo_count <= ($clog2(DEPTH)+1)'(DEPTH-FIFO_SLACK);
      stage_reg.line_valid <= take;
      stage_reg.data_valid <= take;
      stage_reg.line_sel <= pix_in.line_sel;
      stage_reg.last <= pix_in.last;
      stage_reg.data <= correct(pix_in.data, off_sel, gain_sel, mode_reg);
    end
  end
  dosc_fifo #(
    .WIDTH($bits(dosc_pix_out_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(stage_reg.data_valid),
    .in_ready(),
    .in_data(stage_reg),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out),
    .count(fifo_count)
  );
  assign fifo_pop = fifo_out_valid && (!pix_out_reg.data_valid || pix_out_ready);
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pix_out_reg <= '0;
    end else if (fifo_pop) begin
      pix_out_reg <= fifo_out;
    end else if (pix_out_ready) begin
      pix_out_reg <= '0;
    end
  end
  assign reg_rdata = reg_rdata_reg;
  assign reg_ack = reg_ack_reg;
  assign pix_in_ready = pix_in_ready_reg;
  assign pix_out = pix_out_reg;
  assign cal_busy = busy_reg;
endmodule
